//--- inc/lcd_pkg.sv
// Constants and types for the LVDS/CMOS channel divider block
package lcd_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    localparam logic [9:0] OFF_CH2_S1  = 10'h199;
    localparam logic [9:0] OFF_CH2_PH  = 10'h19A;
    localparam logic [9:0] OFF_CH2_S2  = 10'h19B;
    localparam logic [9:0] OFF_CH2_CTL = 10'h19C;
    localparam logic [9:0] OFF_CH2_DCC = 10'h19D;
    localparam logic [9:0] OFF_CH3_S1  = 10'h19E;

    // Count registers: low count in upper nibble, high in lower
    localparam int LO_MSB = 7;
    localparam int LO_LSB = 4;
    localparam int HI_MSB = 3;
    localparam int HI_LSB = 0;

    // Phase offsets: stage 2 upper nibble, stage 1 lower nibble
    localparam int PH2_MSB = 7;
    localparam int PH2_LSB = 4;
    localparam int PH1_MSB = 3;
    localparam int PH1_LSB = 0;

    // Control register bits
    localparam int CTL_W      = 6;
    localparam int CTL_BYP2   = 5;
    localparam int CTL_BYP1   = 4;
    localparam int CTL_NOSYNC = 3;
    localparam int CTL_FORCE  = 2;
    localparam int CTL_START2 = 1;
    localparam int CTL_START1 = 0;
    localparam int DCC_OFF    = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_CTL  = 6'h00;
    localparam logic       RST_DCC  = 1'h0;

    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_WAIT = 4'h2,
        ST_HI   = 4'h4,
        ST_LO   = 4'h8
    } lcd_state_t;
endpackage

//--- inc/lcd_stage_if.sv
// Configuration and clock signals between the top and one divider stage
interface lcd_stage_if;
    logic [3:0] lo_cnt;
    logic [3:0] hi_cnt;
    logic [3:0] phase;
    logic       bypass;
    logic       start_high;
    logic       hold;
    logic       in_lvl;
    logic       in_adv;
    logic       out_lvl;
    logic       out_adv;

    modport ctl (
        output lo_cnt, hi_cnt, phase, bypass, start_high, hold,
        output in_lvl, in_adv,
        input  out_lvl, out_adv
    );
    modport stg (
        input  lo_cnt, hi_cnt, phase, bypass, start_high, hold,
        input  in_lvl, in_adv,
        output out_lvl, out_adv
    );
endinterface

//--- rtl/lcd_div_stage.sv
// One high/low count divider stage with phase offset and bypass
module lcd_div_stage (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    lcd_stage_if.stg  s
);
    lcd_pkg::lcd_state_t st_q;
    lcd_pkg::lcd_state_t st_d;
    logic [3:0]          cnt_q;
    logic [3:0]          cnt_d;
    logic [3:0]          seen_q;
    logic [3:0]          seen_d;
    logic                lvl_q;
    logic                lvl_d;
    logic                adv_q;
    logic                adv_d;

    function automatic lcd_pkg::lcd_state_t lvl_state(input logic hi);
        return hi ? lcd_pkg::ST_HI : lcd_pkg::ST_LO;
    endfunction

    function automatic logic [3:0] lvl_count(input logic hi,
                                             input logic [3:0] h,
                                             input logic [3:0] l);
        return hi ? h : l;
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        lvl_d  = lvl_q;
        seen_d = seen_q;
        if (s.bypass) begin
            // Counting logic parked while bypassed
            st_d  = lcd_pkg::ST_OFF; // RULE6 RULE7
            cnt_d = 4'h0;
        end else if (s.hold || st_q == lcd_pkg::ST_OFF) begin
            // Restart at phase offset with chosen start level
            lvl_d  = s.start_high; // RULE15 RULE11 RULE12
            seen_d = 4'h0;
            if (s.phase == 4'h0) begin
                st_d  = lvl_state(s.start_high);
                cnt_d = lvl_count(s.start_high, s.hi_cnt, s.lo_cnt);
            end else begin
                st_d  = lcd_pkg::ST_WAIT; // RULE5
                cnt_d = s.phase;
            end
        end else if (s.in_adv) begin
            case (st_q)
                lcd_pkg::ST_WAIT: begin
                    if (cnt_q == 4'h1) begin
                        st_d  = lvl_state(lvl_q);
                        cnt_d = lvl_count(lvl_q, s.hi_cnt, s.lo_cnt);
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                lcd_pkg::ST_HI: begin
                    if (cnt_q == 4'h0) begin
                        st_d   = lcd_pkg::ST_LO; // RULE2 RULE3 RULE4
                        cnt_d  = s.lo_cnt;
                        lvl_d  = 1'h0;
                        seen_d = 4'h0;
                    end else begin
                        cnt_d  = cnt_q - 4'h1;
                        seen_d = seen_q + 4'h1;
                    end
                end
                lcd_pkg::ST_LO: begin
                    if (cnt_q == 4'h0) begin
                        st_d   = lcd_pkg::ST_HI; // RULE1 RULE3 RULE4
                        cnt_d  = s.hi_cnt;
                        lvl_d  = 1'h1;
                        seen_d = 4'h0;
                    end else begin
                        cnt_d  = cnt_q - 4'h1;
                        seen_d = seen_q + 4'h1;
                    end
                end
                default: begin
                    st_d = lcd_pkg::ST_OFF;
                end
            endcase
        end
        adv_d = lvl_d & ~lvl_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q   <= lcd_pkg::ST_OFF;
            cnt_q  <= 4'h0;
            seen_q <= 4'h0;
            lvl_q  <= 1'h0;
            adv_q  <= 1'h0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            seen_q <= seen_d;
            lvl_q  <= lvl_d;
            adv_q  <= adv_d;
        end
    end

    // Bypass routes the input clock straight through
    assign s.out_lvl = s.bypass ? s.in_lvl : lvl_q; // RULE6 RULE7
    assign s.out_adv = s.bypass ? s.in_adv : adv_q;

    ////////////////////////////////////////////////////////////////////
    property p_stg_hold;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s.hold && !s.bypass |=> lvl_q == $past(s.start_high);
    endproperty
    a_stg_hold: assert property (p_stg_hold) // RULE15
        else $error("stage did not restart at start level");

    property p_stg_off;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s.bypass ##1 s.bypass |-> st_q == lcd_pkg::ST_OFF && cnt_q == 4'h0;
    endproperty
    a_stg_off: assert property (p_stg_off) // RULE6
        else $error("bypassed stage kept counting");

    property p_stg_high_len;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !s.hold && !s.bypass && s.in_adv
            && st_q == lcd_pkg::ST_HI && st_d == lcd_pkg::ST_LO
            |-> seen_q == s.hi_cnt;
    endproperty
    a_stg_high_len: assert property (p_stg_high_len) // RULE2
        else $error("high phase length differs from count plus one");

    property p_stg_low_len;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !s.hold && !s.bypass && s.in_adv
            && st_q == lcd_pkg::ST_LO && st_d == lcd_pkg::ST_HI
            |-> seen_q == s.lo_cnt;
    endproperty
    a_stg_low_len: assert property (p_stg_low_len) // RULE1
        else $error("low phase length differs from count plus one");
endmodule

//--- rtl/lcd_dividers.sv
// Channel 2 two-stage divider and channel 3 first stage with registers

// How it works
// RULE1: Stage one low time is field plus one
// RULE2: Stage one high time is field plus one
// RULE3: Stage two counts from its own register
// RULE4: Channel three stage one counts, reset zero
// RULE5: Four-bit phase offset per channel two stage
// RULE6: Stage two bypass passes input clock through
// RULE7: Stage one bypass passes input clock through
// RULE8: Sync mask zero obeys sync, one ignores
// RULE9: Forced-level bit sets output high or low
// RULE10: Software sets sync mask when forcing level
// RULE11: Stage two start polarity after sync
// RULE12: Stage one start polarity after sync
// RULE13: Duty correction enabled while disable bit zero
// RULE14: Stage two clocked by stage one output
// RULE15: Sync restarts counters at phase, start level
module lcd_dividers (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_dist_clk,
    input  wire logic       i_sync_n,
    input  wire logic [9:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_we,
    input  wire logic       i_reg_re,
    output logic      [7:0] o_reg_rdata,
    output logic            o_ch2_clk,
    output logic            o_ch3_stage1_clk,
    output logic            o_ch2_duty_fix_en
);
    logic [7:0] ch2_s1_q;
    logic [7:0] ch2_s1_d;
    logic [7:0] ch2_ph_q;
    logic [7:0] ch2_ph_d;
    logic [7:0] ch2_s2_q;
    logic [7:0] ch2_s2_d;
    logic [5:0] ctl_q;
    logic [5:0] ctl_d;
    logic       dcc_off_q;
    logic       dcc_off_d;
    logic [7:0] ch3_s1_q;
    logic [7:0] ch3_s1_d;
    logic [7:0] rdata_d;

    logic       sync_meta_q;
    logic       sync_q;
    logic       dclk_meta_q;
    logic       dclk_q;
    logic       dclk_prev_q;
    logic       dclk_rise;
    logic       ch2_forced;
    logic       ch2_clk_d;
    logic       ch3_clk_d;

    lcd_stage_if s1 ();
    lcd_stage_if s2 ();
    lcd_stage_if s3 ();

    function automatic logic [7:0] read_mux(
        input logic [9:0] a,
        input logic [7:0] r199,
        input logic [7:0] r19a,
        input logic [7:0] r19b,
        input logic [5:0] r19c,
        input logic       r19d,
        input logic [7:0] r19e
    );
        case (a)
            lcd_pkg::OFF_CH2_S1:  read_mux = r199;
            lcd_pkg::OFF_CH2_PH:  read_mux = r19a;
            lcd_pkg::OFF_CH2_S2:  read_mux = r19b;
            lcd_pkg::OFF_CH2_CTL: read_mux = {2'h0, r19c};
            lcd_pkg::OFF_CH2_DCC: read_mux = {7'h00, r19d};
            lcd_pkg::OFF_CH3_S1:  read_mux = r19e;
            default:              read_mux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        ch2_s1_d  = ch2_s1_q;
        ch2_ph_d  = ch2_ph_q;
        ch2_s2_d  = ch2_s2_q;
        ctl_d     = ctl_q;
        dcc_off_d = dcc_off_q;
        ch3_s1_d  = ch3_s1_q;
        if (i_reg_we) begin
            case (i_reg_addr)
                lcd_pkg::OFF_CH2_S1:  ch2_s1_d  = i_reg_wdata;
                lcd_pkg::OFF_CH2_PH:  ch2_ph_d  = i_reg_wdata;
                lcd_pkg::OFF_CH2_S2:  ch2_s2_d  = i_reg_wdata;
                lcd_pkg::OFF_CH2_CTL: ctl_d     = i_reg_wdata[5:0];
                lcd_pkg::OFF_CH2_DCC: dcc_off_d =
                    i_reg_wdata[lcd_pkg::DCC_OFF];
                lcd_pkg::OFF_CH3_S1:  ch3_s1_d  = i_reg_wdata;
                default: begin
                end
            endcase
        end
        rdata_d = o_reg_rdata;
        if (i_reg_re) begin
            rdata_d = read_mux(i_reg_addr, ch2_s1_q, ch2_ph_q, ch2_s2_q,
                               ctl_q, dcc_off_q, ch3_s1_q);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ch2_s1_q    <= lcd_pkg::RST_BYTE;
            ch2_ph_q    <= lcd_pkg::RST_BYTE;
            ch2_s2_q    <= lcd_pkg::RST_BYTE;
            ctl_q       <= lcd_pkg::RST_CTL;
            dcc_off_q   <= lcd_pkg::RST_DCC;
            ch3_s1_q    <= lcd_pkg::RST_BYTE;
            o_reg_rdata <= 8'h00;
        end else begin
            ch2_s1_q    <= ch2_s1_d;
            ch2_ph_q    <= ch2_ph_d;
            ch2_s2_q    <= ch2_s2_d;
            ctl_q       <= ctl_d;
            dcc_off_q   <= dcc_off_d;
            ch3_s1_q    <= ch3_s1_d;
            o_reg_rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and distribution clock edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync_meta_q <= 1'h0;
            sync_q      <= 1'h0;
            dclk_meta_q <= 1'h0;
            dclk_q      <= 1'h0;
            dclk_prev_q <= 1'h0;
        end else begin
            sync_meta_q <= ~i_sync_n;
            sync_q      <= sync_meta_q;
            dclk_meta_q <= i_dist_clk;
            dclk_q      <= dclk_meta_q;
            dclk_prev_q <= dclk_q;
        end
    end

    assign dclk_rise = dclk_q & ~dclk_prev_q;

    ////////////////////////////////////////////////////////////////////
    // Stage wiring
    assign s1.lo_cnt     = ch2_s1_q[lcd_pkg::LO_MSB:lcd_pkg::LO_LSB];
    assign s1.hi_cnt     = ch2_s1_q[lcd_pkg::HI_MSB:lcd_pkg::HI_LSB];
    assign s1.phase      = ch2_ph_q[lcd_pkg::PH1_MSB:lcd_pkg::PH1_LSB];
    assign s1.bypass     = ctl_q[lcd_pkg::CTL_BYP1]; // RULE7
    assign s1.start_high = ctl_q[lcd_pkg::CTL_START1]; // RULE12
    assign s1.hold       = sync_q & ~ctl_q[lcd_pkg::CTL_NOSYNC]; // RULE8
    assign s1.in_lvl     = dclk_q;
    assign s1.in_adv     = dclk_rise;

    assign s2.lo_cnt     = ch2_s2_q[lcd_pkg::LO_MSB:lcd_pkg::LO_LSB];
    assign s2.hi_cnt     = ch2_s2_q[lcd_pkg::HI_MSB:lcd_pkg::HI_LSB];
    assign s2.phase      = ch2_ph_q[lcd_pkg::PH2_MSB:lcd_pkg::PH2_LSB];
    assign s2.bypass     = ctl_q[lcd_pkg::CTL_BYP2]; // RULE6
    assign s2.start_high = ctl_q[lcd_pkg::CTL_START2]; // RULE11
    assign s2.hold       = s1.hold; // RULE8
    assign s2.in_lvl     = s1.out_lvl; // RULE14
    assign s2.in_adv     = s1.out_adv; // RULE14

    // Channel 3 first stage: only its counts are controllable here
    assign s3.lo_cnt     = ch3_s1_q[lcd_pkg::LO_MSB:lcd_pkg::LO_LSB];
    assign s3.hi_cnt     = ch3_s1_q[lcd_pkg::HI_MSB:lcd_pkg::HI_LSB];
    assign s3.phase      = 4'h0;
    assign s3.bypass     = 1'h0;
    assign s3.start_high = 1'h0;
    assign s3.hold       = sync_q;
    assign s3.in_lvl     = dclk_q;
    assign s3.in_adv     = dclk_rise;

    lcd_div_stage u_ch2_stage1 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .s          (s1.stg)
    );

    lcd_div_stage u_ch2_stage2 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .s          (s2.stg)
    );

    lcd_div_stage u_ch3_stage1 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .s          (s3.stg)
    );

    ////////////////////////////////////////////////////////////////////
    // Outputs; forced level holds while sync is masked and asserted
    assign ch2_forced = sync_q & ctl_q[lcd_pkg::CTL_NOSYNC]; // RULE10

    always_comb begin
        ch2_clk_d = s2.out_lvl;
        if (ch2_forced) begin
            ch2_clk_d = ctl_q[lcd_pkg::CTL_FORCE]; // RULE9
        end
        ch3_clk_d = s3.out_lvl;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_ch2_clk         <= 1'h0;
            o_ch3_stage1_clk  <= 1'h0;
            o_ch2_duty_fix_en <= 1'h1;
        end else begin
            o_ch2_clk         <= ch2_clk_d;
            o_ch3_stage1_clk  <= ch3_clk_d;
            o_ch2_duty_fix_en <= ~dcc_off_d; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_s1_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_reg_we && i_reg_addr == lcd_pkg::OFF_CH2_S1
            |=> s1.lo_cnt == $past(i_reg_wdata[7:4])
                && s1.hi_cnt == $past(i_reg_wdata[3:0]);
    endproperty
    a_s1_write: assert property (p_s1_write) // RULE1
        else $error("stage one counts not taken from write");

    property p_dcc;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_reg_we && i_reg_addr == lcd_pkg::OFF_CH2_DCC
            |=> o_ch2_duty_fix_en == !$past(i_reg_wdata[0]);
    endproperty
    a_dcc: assert property (p_dcc) // RULE13
        else $error("duty correction enable wrong after write");

    property p_force;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        sync_q && ctl_q[lcd_pkg::CTL_NOSYNC]
            |=> o_ch2_clk == $past(ctl_q[lcd_pkg::CTL_FORCE]);
    endproperty
    a_force: assert property (p_force) // RULE9
        else $error("channel output not at forced level");

    property p_obey;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        sync_q && !ctl_q[lcd_pkg::CTL_NOSYNC] && !ctl_q[lcd_pkg::CTL_BYP1]
            ##1 !ctl_q[lcd_pkg::CTL_BYP1]
            |-> s1.out_lvl == $past(ctl_q[lcd_pkg::CTL_START1]);
    endproperty
    a_obey: assert property (p_obey) // RULE8
        else $error("stage one did not obey sync");
endmodule

//--- bench/lcd_testbench.sv
// Self-checking testbench for the channel divider block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DP    = 8;
    localparam int LIMIT = 20000;

    logic       i_core_clk;
    logic       i_sys_rst;
    logic       i_dist_clk = 1'b0;
    logic       i_sync_n;
    logic [9:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic       i_reg_we;
    logic       i_reg_re;
    logic [7:0] o_reg_rdata;
    logic       o_ch2_clk;
    logic       o_ch3_stage1_clk;
    logic       o_ch2_duty_fix_en;
    logic [1:0] dcnt = 2'h0;
    int         err_count;
    int         n_checks;
    int         cyc = 0;

    lcd_dividers u_dut (
        .i_core_clk        (i_core_clk),
        .i_sys_rst         (i_sys_rst),
        .i_dist_clk        (i_dist_clk),
        .i_sync_n          (i_sync_n),
        .i_reg_addr        (i_reg_addr),
        .i_reg_wdata       (i_reg_wdata),
        .i_reg_we          (i_reg_we),
        .i_reg_re          (i_reg_re),
        .o_reg_rdata       (o_reg_rdata),
        .o_ch2_clk         (o_ch2_clk),
        .o_ch3_stage1_clk  (o_ch3_stage1_clk),
        .o_ch2_duty_fix_en (o_ch2_duty_fix_en)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Distribution clock: half period of four core cycles
    always @(posedge i_core_clk) begin
        dcnt <= dcnt + 2'h1;
        if (dcnt == 2'h3) begin
            i_dist_clk <= ~i_dist_clk;
        end
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_we    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_we    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_reg_re   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_re   <= 1'b0;
        step();
        chk({8'h00, o_reg_rdata}, {8'h00, exp});
    endtask

    // Length of one high and one low level, in core cycles
    task automatic measure(input bit sel, output int hi, output int lo);
        int n;
        hi = 0;
        lo = 0;
        n  = 0;
        while ((sel ? o_ch3_stage1_clk : o_ch2_clk) !== 1'b0 && n < 900) begin
            step();
            n++;
        end
        while ((sel ? o_ch3_stage1_clk : o_ch2_clk) !== 1'b1 && n < 900) begin
            step();
            n++;
        end
        while ((sel ? o_ch3_stage1_clk : o_ch2_clk) === 1'b1 && hi < 900) begin
            step();
            hi++;
        end
        while ((sel ? o_ch3_stage1_clk : o_ch2_clk) === 1'b0 && lo < 900) begin
            step();
            lo++;
        end
    endtask

    // Program under held sync, release, check one period
    // Expected lengths are in half periods of the input clock
    task automatic run_div(input logic [7:0] s1, input logic [7:0] s2,
                           input logic [7:0] c3, input logic [7:0] ctl,
                           input bit sel, input int ehi, input int elo);
        int hi;
        int lo;
        @(posedge i_core_clk);
        i_sync_n <= 1'b0;
        repeat (10) step();
        wr(10'h199, s1);
        wr(10'h19A, 8'h00);
        wr(10'h19B, s2);
        wr(10'h19E, c3);
        wr(10'h19C, ctl);
        @(posedge i_core_clk);
        i_sync_n <= 1'b1;
        measure(sel, hi, lo);
        measure(sel, hi, lo);
        chk(16'(hi), 16'(ehi * DP / 2));
        chk(16'(lo), 16'(elo * DP / 2));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 'h199; a <= 'h19E; a++) begin
            rd_chk(10'(a), 8'h00);
        end
        rd_chk(10'h198, 8'h00);
        rd_chk(10'h19F, 8'h00);
        chk({15'h0000, o_ch2_duty_fix_en}, 16'h0001);
    endtask

    task automatic t_regs();
        @(posedge i_core_clk);
        i_sync_n <= 1'b0;
        wr(10'h199, 8'hA5);
        wr(10'h19A, 8'h5A);
        wr(10'h19B, 8'hC3);
        wr(10'h19C, 8'hFF);
        wr(10'h19D, 8'hFF);
        wr(10'h19E, 8'h3C);
        wr(10'h19F, 8'hAA);
        rd_chk(10'h199, 8'hA5);
        rd_chk(10'h19A, 8'h5A);
        rd_chk(10'h19B, 8'hC3);
        rd_chk(10'h19C, 8'h3F);
        rd_chk(10'h19D, 8'h01);
        rd_chk(10'h19E, 8'h3C);
        rd_chk(10'h19F, 8'h00);
        chk({15'h0000, o_ch2_duty_fix_en}, 16'h0000);
        wr(10'h19D, 8'h00);
        wr(10'h19C, 8'h00);
        repeat (3) step();
        chk({15'h0000, o_ch2_duty_fix_en}, 16'h0001);
    endtask

    task automatic t_stage1();
        run_div(8'h21, 8'h00, 8'h00, 8'h20, 1'b0, 4, 6);
    endtask

    task automatic t_ch3();
        run_div(8'h00, 8'h00, 8'h12, 8'h20, 1'b1, 6, 4);
    endtask

    task automatic t_cascade();
        run_div(8'h00, 8'h10, 8'h00, 8'h00, 1'b0, 4, 8);
    endtask

    task automatic t_bypass();
        run_div(8'h33, 8'h77, 8'h00, 8'h30, 1'b0, 1, 1);
    endtask

    // Held sync keeps each selected start level
    task automatic t_start();
        logic [7:0] ctl [4] = '{8'h21, 8'h20, 8'h02, 8'h00};
        logic       lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        @(posedge i_core_clk);
        i_sync_n <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(10'h19C, ctl[k]);
            repeat (60) step();
            chk({15'h0000, o_ch2_clk}, {15'h0000, lvl[k]});
        end
    endtask

    // Sync held: output shows the forced level while masked, then the start level once unmasked
    task automatic t_force();
        @(posedge i_core_clk);
        i_sync_n <= 1'b0;
        wr(10'h19C, 8'h2C);
        repeat (10) step();
        chk({15'h0000, o_ch2_clk}, 16'h0001);
        wr(10'h19C, 8'h28);
        repeat (10) step();
        chk({15'h0000, o_ch2_clk}, 16'h0000);
        wr(10'h19C, 8'h21);
        repeat (10) step();
        chk({15'h0000, o_ch2_clk}, 16'h0001);
    endtask

    // Delay from sync release to first rise, for a phase offset
    task automatic first_rise(input logic [7:0] ph, output int t);
        @(posedge i_core_clk);
        i_sync_n <= 1'b0;
        wr(10'h199, 8'h00);
        wr(10'h19A, ph);
        wr(10'h19C, 8'h20);
        repeat (20) step();
        do @(posedge i_core_clk);
        while (!(dcnt == 2'h0 && i_dist_clk == 1'b0));
        i_sync_n <= 1'b1;
        t = 0;
        step();
        while (o_ch2_clk !== 1'b1 && t < 900) begin
            step();
            t++;
        end
    endtask

    task automatic t_phase();
        int t0;
        int t3;
        first_rise(8'h00, t0);
        first_rise(8'h03, t3);
        chk(16'(t3 - t0), 16'(3 * DP));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_rst   = 1'b1;
        i_sync_n    = 1'b1;
        i_reg_addr  = 10'h000;
        i_reg_wdata = 8'h00;
        i_reg_we    = 1'b0;
        i_reg_re    = 1'b0;
        err_count   = 0;
        n_checks    = 0;
        repeat (10) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_stage1();
        t_ch3();
        t_cascade();
        t_bypass();
        t_start();
        t_force();
        t_phase();
        end_sim();
    end
endmodule
